// ==== design/slot_status_pkg.sv ====
// Constants shared by both ends of the slot status and fault link
package slot_status_pkg;
  // =====================================================
  // Device command bytes
  localparam logic [7:0] CMD_CTRL_A = 8'h02;
  localparam logic [7:0] CMD_CTRL_B = 8'h03;
  localparam logic [7:0] CMD_STAT_A = 8'h04;
  localparam logic [7:0] CMD_STAT_B = 8'h05;
  localparam logic [7:0] CMD_COMMON = 8'h06;
  localparam logic [7:0] STAT_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] COMMON_RESET = 8'h00;

  // =====================================================
  // Status register fields
  localparam int STAT_FAULT_BIT = 7;
  localparam int STAT_MAIN_BIT = 6;
  localparam int STAT_AUX_BIT = 5;
  localparam int STAT_AUXOC_BIT = 4;
  localparam int STAT_R12OC_BIT = 2;
  localparam int STAT_R3OC_BIT = 0;
  localparam logic [7:0] STAT_FLAG_MASK = 8'h15;

  // =====================================================
  // Control and common register fields
  localparam int CTRL_GATE_BIT = 2;
  localparam int CTRL_MAIN_BIT = 1;
  localparam int CTRL_AUX_BIT = 0;
  localparam logic [7:0] CTRL_WR_MASK = 8'h07;
  localparam int COMMON_MASK_BIT = 3;

  // =====================================================
  // Host Avalon map (byte addresses)
  localparam logic [4:0] AV_CMD = 5'h00;
  localparam logic [4:0] AV_STATUS = 5'h04;
  localparam logic [4:0] AV_IRQ_STATUS = 5'h08;
  localparam logic [4:0] AV_IRQ_MASK = 5'h0c;
  localparam logic [4:0] AV_PINS = 5'h10;
  localparam logic [31:0] AV_UNMAPPED = 32'h0000_0000;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_ALERT_BIT = 1;
  localparam logic [5:0] PINS_RESET = 6'h30;
endpackage

// ==== design/slot_link_if.sv ====
// Interface joining the host controller to the slot status device
`timescale 1ns/1ps
interface slot_link_if;
  logic cmd_req;
  logic cmd_write;
  logic [7:0] cmd_code;
  logic [7:0] cmd_wdata;
  logic cmd_ack;
  logic [7:0] cmd_rdata;
  logic [1:0] main_request;
  logic [1:0] aux_request;
  logic [1:0] override_in_n;
  logic [1:0] fault_out_n_o;
  logic [1:0] fault_out_n_oe;
  logic int_n_o;
  logic int_n_oe;
  logic [1:0] fault_out_n;
  logic int_n;

  // Open-drain wires with pull-ups: low only while someone drives low
  assign fault_out_n = ~fault_out_n_oe | fault_out_n_o;
  assign int_n = ~int_n_oe | int_n_o;

  modport device (
    input cmd_req, cmd_write, cmd_code, cmd_wdata,
    output cmd_ack, cmd_rdata,
    input main_request, aux_request, override_in_n,
    output fault_out_n_o, fault_out_n_oe, int_n_o, int_n_oe
  );
  modport host (
    output cmd_req, cmd_write, cmd_code, cmd_wdata,
    input cmd_ack, cmd_rdata,
    output main_request, aux_request, override_in_n,
    input fault_out_n, int_n
  );
endinterface

// ==== design/slot_status_device.sv ====
// Two-slot status and fault register bank of the hot-swap controller
//
// Register access over Avalon-MM was decided locally.
`timescale 1ns/1ps
module slot_status_device (
  input wire logic mclk_i,
  input wire logic rst_i,
  slot_link_if.device link,
  input wire logic [1:0] aux_oc_i,
  input wire logic [1:0] rail12_oc_i,
  input wire logic [1:0] rail3_oc_i,
  output logic [1:0] main_power_o,
  output logic [1:0] aux_power_o
);

  // =====================================================
  // Pin synchronisers
  logic [1:0] main_req_s1;
  logic [1:0] main_req_s2;
  logic [1:0] aux_req_s1;
  logic [1:0] aux_req_s2;
  logic [1:0] ovr_n_s1;
  logic [1:0] ovr_n_s2;

  // Request and override pins come from outside this clock domain
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      main_req_s1 <= 2'h0;
      main_req_s2 <= 2'h0;
      aux_req_s1 <= 2'h0;
      aux_req_s2 <= 2'h0;
      ovr_n_s1 <= 2'h3;
      ovr_n_s2 <= 2'h3;
    end else begin
      main_req_s1 <= link.main_request;
      main_req_s2 <= main_req_s1;
      aux_req_s1 <= link.aux_request;
      aux_req_s2 <= aux_req_s1;
      ovr_n_s1 <= link.override_in_n;
      ovr_n_s2 <= ovr_n_s1;
    end
  end

  // =====================================================
  // Command port decode
  logic cmd_take;
  logic wr_take;
  logic [7:0] ctrl [2];
  logic [7:0] common;
  logic [7:0] stat_rd [2];
  logic [1:0] flag_aux;
  logic [1:0] flag_r12;
  logic [1:0] flag_r3;
  logic [1:0] main_trip;
  logic [1:0] aux_trip;
  logic [1:0] fault_status;
  logic [1:0] fault_drive;

  // A request is taken once; ack drops it out of the held request
  assign cmd_take = link.cmd_req && !link.cmd_ack;
  assign wr_take = cmd_take && link.cmd_write;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      link.cmd_ack <= 1'b0;
    end else begin
      link.cmd_ack <= cmd_take;
    end
  end

  // Read data mux; reading has no side effect on pins or flags
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      link.cmd_rdata <= 8'h00;
    end else if (cmd_take && !link.cmd_write) begin
      unique case (link.cmd_code)
        slot_status_pkg::CMD_CTRL_A: link.cmd_rdata <= ctrl[0];
        slot_status_pkg::CMD_CTRL_B: link.cmd_rdata <= ctrl[1];
        slot_status_pkg::CMD_STAT_A: link.cmd_rdata <= stat_rd[0];
        slot_status_pkg::CMD_STAT_B: link.cmd_rdata <= stat_rd[1];
        slot_status_pkg::CMD_COMMON: link.cmd_rdata <= common;
        default: link.cmd_rdata <= 8'h00;
      endcase
    end
  end

  // Common register: only the interrupt mask is held here
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      common <= slot_status_pkg::COMMON_RESET;
    end else if (wr_take && link.cmd_code == slot_status_pkg::CMD_COMMON) begin
      common <= link.cmd_wdata & (8'h01 << slot_status_pkg::COMMON_MASK_BIT);
    end
  end

  // =====================================================
  // Per-slot power path, fault and flags
  genvar s;
  generate
    for (s = 0; s < 2; s++) begin : g_slot
      logic [7:0] ctrl_code;
      logic [7:0] stat_code;
      logic wr_ctrl;
      logic wr_stat;
      logic main_on;
      logic aux_on;
      logic main_oc;
      logic pin_mode;
      logic override_on;

      assign ctrl_code = (s == 0) ? slot_status_pkg::CMD_CTRL_A : slot_status_pkg::CMD_CTRL_B;
      assign stat_code = (s == 0) ? slot_status_pkg::CMD_STAT_A : slot_status_pkg::CMD_STAT_B;
      assign wr_ctrl = wr_take && link.cmd_code == ctrl_code;
      assign wr_stat = wr_take && link.cmd_code == stat_code;
      assign main_on = main_power_o[s];
      assign aux_on = aux_power_o[s];
      assign main_oc = rail12_oc_i[s] || rail3_oc_i[s];
      // Power under register control when either enable bit is set
      assign pin_mode = !(ctrl[s][slot_status_pkg::CTRL_MAIN_BIT]
                          || ctrl[s][slot_status_pkg::CTRL_AUX_BIT]);
      // Override counts only while the gate bit is clear
      assign override_on = !ovr_n_s2[s]
                           && !ctrl[s][slot_status_pkg::CTRL_GATE_BIT];

      // Control register; a trip drops the register enable like a breaker
      always_ff @(posedge mclk_i) begin
        if (rst_i) begin
          ctrl[s] <= slot_status_pkg::CTRL_RESET;
        end else begin
          if (wr_ctrl) begin
            ctrl[s] <= link.cmd_wdata & slot_status_pkg::CTRL_WR_MASK;
          end
          if (main_on && main_oc) begin
            ctrl[s][slot_status_pkg::CTRL_MAIN_BIT] <= 1'b0;
          end
          if (aux_on && aux_oc_i[s]) begin
            ctrl[s][slot_status_pkg::CTRL_AUX_BIT] <= 1'b0;
          end
        end
      end

      // Trip latches; each is released only by its own request going low
      always_ff @(posedge mclk_i) begin
        if (rst_i) begin
          main_trip[s] <= 1'b0;
          aux_trip[s] <= 1'b0;
        end else begin
          if (main_on && main_oc) begin
            main_trip[s] <= 1'b1;
          end else if (!main_req_s2[s]) begin
            main_trip[s] <= 1'b0;
          end
          if (aux_on && aux_oc_i[s]) begin
            aux_trip[s] <= 1'b1;
          end else if (!aux_req_s2[s]) begin
            aux_trip[s] <= 1'b0;
          end
        end
      end

      // In pin mode the fault holds while either trip stands, so the request of each tripped supply must drop
      assign fault_status[s] = (main_trip[s] || aux_trip[s]) && pin_mode;

      // Actual supply state; off at reset and off while tripped
      always_ff @(posedge mclk_i) begin
        if (rst_i) begin
          main_power_o[s] <= 1'b0;
          aux_power_o[s] <= 1'b0;
        end else begin
          main_power_o[s] <= (main_req_s2[s] || ctrl[s][slot_status_pkg::CTRL_MAIN_BIT])
                             && !main_trip[s] && !(main_on && main_oc);
          aux_power_o[s] <= (aux_req_s2[s] || ctrl[s][slot_status_pkg::CTRL_AUX_BIT])
                            && !aux_trip[s] && !(aux_on && aux_oc_i[s]);
        end
      end

      // Sticky flags: a new event in the clearing cycle wins over the clear
      always_ff @(posedge mclk_i) begin
        if (rst_i) begin
          flag_aux[s] <= 1'b0;
          flag_r12[s] <= 1'b0;
          flag_r3[s] <= 1'b0;
        end else begin
          flag_aux[s] <= (aux_on && aux_oc_i[s]) || (flag_aux[s] && !(wr_stat
                         && link.cmd_wdata[slot_status_pkg::STAT_AUXOC_BIT]));
          flag_r12[s] <= (main_on && rail12_oc_i[s]) || (flag_r12[s] && !(wr_stat
                         && link.cmd_wdata[slot_status_pkg::STAT_R12OC_BIT]));
          flag_r3[s] <= (main_on && rail3_oc_i[s]) || (flag_r3[s] && !(wr_stat
                        && link.cmd_wdata[slot_status_pkg::STAT_R3OC_BIT]));
        end
      end

      // Fault pin follows the fault status unless override is on, never reads or clears
      always_ff @(posedge mclk_i) begin
        if (rst_i) begin
          fault_drive[s] <= 1'b0;
        end else begin
          fault_drive[s] <= fault_status[s] && !override_on;
        end
      end

      // Status byte; bit 7 reports the fault irrespective of override
      always_comb begin
        stat_rd[s] = slot_status_pkg::STAT_RESET;
        stat_rd[s][slot_status_pkg::STAT_FAULT_BIT] = fault_status[s];
        stat_rd[s][slot_status_pkg::STAT_MAIN_BIT] = main_on;
        stat_rd[s][slot_status_pkg::STAT_AUX_BIT] = aux_on;
        stat_rd[s][slot_status_pkg::STAT_AUXOC_BIT] = flag_aux[s];
        stat_rd[s][slot_status_pkg::STAT_R12OC_BIT] = flag_r12[s];
        stat_rd[s][slot_status_pkg::STAT_R3OC_BIT] = flag_r3[s];
      end
    end
  endgenerate

  // =====================================================
  // Open-drain pins
  logic int_drive;

  // Interrupt stays low until every flag of both slots is cleared or the mask bit is set
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      int_drive <= 1'b0;
    end else begin
      int_drive <= (|{flag_aux, flag_r12, flag_r3})
                   && !common[slot_status_pkg::COMMON_MASK_BIT];
    end
  end

  assign link.int_n_o = 1'b0;
  assign link.int_n_oe = int_drive;
  assign link.fault_out_n_o = 2'h0;
  assign link.fault_out_n_oe = fault_drive;

endmodule

// ==== design/slot_status_host.sv ====
// Management host: Avalon-MM registers in, command port and slot pins out
`timescale 1ns/1ps
module slot_status_host (
  input wire logic mclk_i,
  input wire logic rst_i,
  slot_link_if.host link,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic irq_o
);

  // =====================================================
  // Pin sampling
  logic int_n_s1;
  logic int_n_s2;
  logic int_n_d;
  logic [1:0] fault_n_s1;
  logic [1:0] fault_n_s2;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      int_n_s1 <= 1'b1;
      int_n_s2 <= 1'b1;
      int_n_d <= 1'b1;
      fault_n_s1 <= 2'h3;
      fault_n_s2 <= 2'h3;
    end else begin
      int_n_s1 <= link.int_n;
      int_n_s2 <= int_n_s1;
      int_n_d <= int_n_s2;
      fault_n_s1 <= link.fault_out_n;
      fault_n_s2 <= fault_n_s1;
    end
  end

  // =====================================================
  // Avalon slave: waitrequest drops one cycle after a request appears
  logic bus_req;
  logic bus_wr;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic [5:0] pins;
  logic [7:0] rdata;
  logic busy;
  logic [1:0] ev;

  assign bus_req = (avs_read_i || avs_write_i) && !avs_waitrequest_o;
  assign bus_wr = bus_req && avs_write_i;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= !((avs_read_i || avs_write_i) && avs_waitrequest_o);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if ((avs_read_i || avs_write_i) && avs_waitrequest_o) begin
      unique case (avs_address_i)
        slot_status_pkg::AV_STATUS:
          avs_readdata_o <= {20'h00000, fault_n_s2, !int_n_s2, busy, rdata};
        slot_status_pkg::AV_IRQ_STATUS: avs_readdata_o <= {30'h0, irq_status};
        slot_status_pkg::AV_IRQ_MASK: avs_readdata_o <= {30'h0, irq_mask};
        slot_status_pkg::AV_PINS: avs_readdata_o <= {26'h0, pins};
        default: avs_readdata_o <= slot_status_pkg::AV_UNMAPPED;
      endcase
    end
  end

  // Pins: [1:0] main request, [3:2] aux request, [5:4] override (low active)
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pins <= slot_status_pkg::PINS_RESET;
    end else if (bus_wr && avs_address_i == slot_status_pkg::AV_PINS) begin
      pins <= avs_writedata_i[5:0];
    end
  end

  assign link.main_request = pins[1:0];
  assign link.aux_request = pins[3:2];
  assign link.override_in_n = pins[5:4];

  // =====================================================
  // Command engine: one transfer in flight, writes while busy are dropped
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      busy <= 1'b0;
      link.cmd_req <= 1'b0;
      link.cmd_write <= 1'b0;
      link.cmd_code <= 8'h00;
      link.cmd_wdata <= 8'h00;
      rdata <= 8'h00;
    end else if (busy) begin
      if (link.cmd_ack) begin
        busy <= 1'b0;
        link.cmd_req <= 1'b0;
        rdata <= link.cmd_rdata;
      end
    end else if (bus_wr && avs_address_i == slot_status_pkg::AV_CMD) begin
      busy <= 1'b1;
      link.cmd_req <= 1'b1;
      link.cmd_write <= avs_writedata_i[16]; // set for every device write: control, common or flag clear
      link.cmd_code <= avs_writedata_i[15:8];
      link.cmd_wdata <= avs_writedata_i[7:0];
    end
  end

  // =====================================================
  // Interrupts: done and device alert, set wins over write-one clear
  assign ev[slot_status_pkg::IRQ_DONE_BIT] = busy && link.cmd_ack;
  assign ev[slot_status_pkg::IRQ_ALERT_BIT] = int_n_d && !int_n_s2;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      irq_status <= 2'h0;
    end else if (bus_wr && avs_address_i == slot_status_pkg::AV_IRQ_STATUS) begin
      irq_status <= ev | (irq_status & ~avs_writedata_i[1:0]);
    end else begin
      irq_status <= ev | irq_status;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      irq_mask <= 2'h0;
    end else if (bus_wr && avs_address_i == slot_status_pkg::AV_IRQ_MASK) begin
      irq_mask <= avs_writedata_i[1:0];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_status & irq_mask);
    end
  end

endmodule

// ==== testbench/slot_link_properties.sv ====
// Concurrent checks on the command link and fault pins between host and device
`timescale 1ns/1ps
module slot_link_properties (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic cmd_req,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] cmd_wdata,
  input wire logic cmd_ack,
  input wire logic [7:0] cmd_rdata,
  input wire logic [1:0] main_request,
  input wire logic [1:0] aux_request,
  input wire logic [1:0] override_in_n,
  input wire logic [1:0] fault_out_n_oe,
  input wire logic int_n_oe,
  input wire logic [1:0] fault_out_n,
  input wire logic int_n
);
  // ==========================================
  // Shadow of gate and mask bits
  logic [1:0] gate;
  logic mask;
  wire take = cmd_req && !cmd_ack && cmd_write;

  // Taken on the accept edge so the shadow never lags the device
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      gate <= 2'h0;
    end else if (take && cmd_code == slot_status_pkg::CMD_CTRL_B) begin
      gate[1] <= cmd_wdata[slot_status_pkg::CTRL_GATE_BIT];
    end
  end

  // Interrupt mask shadow
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      mask <= 1'b0;
    end else if (take && cmd_code == slot_status_pkg::CMD_COMMON) begin
      mask <= cmd_wdata[slot_status_pkg::COMMON_MASK_BIT];
    end
  end

  // ==========================================
  // Properties
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  ack_single_pulse_a:
    assert property (cmd_ack |=> !cmd_ack) else $error("Ack longer than one cycle");
  ack_in_time_a:
    assert property ($rose(cmd_req) |-> ##[1:2] cmd_ack) else $error("Ack late");
  reset_quiet_a:
    assert property ($fell(rst_i) |-> fault_out_n_oe == 2'h0 && !int_n_oe)
    else $error("Pins driven after reset");
  reserved_zero_a:
    assert property (cmd_ack && !cmd_write && cmd_code[7:1] == 7'h02
      |-> cmd_rdata[3] == 1'b0 && cmd_rdata[1] == 1'b0) else $error("Reserved bit set");
  unknown_code_a:
    assert property (cmd_ack && !cmd_write && (cmd_code < 8'h02 || cmd_code > 8'h06)
      |-> cmd_rdata == 8'h00) else $error("Unknown code read nonzero");
  override_release_a:
    assert property ((!override_in_n[1] && !gate[1])[*7] |-> fault_out_n[1])
    else $error("Fault pin held under override");
  fault_hold_a:
    assert property (!fault_out_n[0] && main_request[0] && aux_request[0]
      && override_in_n[0] |=> !fault_out_n[0]) else $error("Fault pin released early");
  int_hold_a:
    assert property (int_n_oe && !cmd_req && !$past(cmd_req) && !$past(cmd_req, 2)
      |=> int_n_oe) else $error("Interrupt dropped without clear");
  mask_quiet_a:
    assert property (mask[*7] |-> !int_n_oe) else $error("Interrupt while masked");
endmodule

// ==== testbench/test_slot_status_fault_regs.sv ====
// Self-checking bench joining host and device through the slot link
`timescale 1ns/1ps
module test_slot_status_fault_regs;
  typedef struct {logic [31:0] exp; logic [31:0] mask;} note_t;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [4:0] avs_address_i = 5'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o, rd;
  logic avs_waitrequest_o, irq_o;
  logic [1:0] aux_oc_i = 2'h0, rail12_oc_i = 2'h0, rail3_oc_i = 2'h0;
  logic [1:0] main_power_o, aux_power_o, sb;
  logic [7:0] s, flag, main_request_b;
  note_t notes[$];
  note_t cur;
  int fail_count = 0;
  int samples_checked = 0;

  slot_link_if link ();
  slot_status_device u_slot_status_device (.mclk_i(mclk_i), .rst_i(rst_i), .link(link),
    .aux_oc_i(aux_oc_i), .rail12_oc_i(rail12_oc_i), .rail3_oc_i(rail3_oc_i),
    .main_power_o(main_power_o), .aux_power_o(aux_power_o));
  slot_status_host u_slot_status_host (.mclk_i(mclk_i), .rst_i(rst_i), .link(link),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o));
  slot_link_properties u_slot_link_properties (.mclk_i(mclk_i), .rst_i(rst_i),
    .cmd_req(link.cmd_req), .cmd_write(link.cmd_write), .cmd_code(link.cmd_code),
    .cmd_wdata(link.cmd_wdata), .cmd_ack(link.cmd_ack), .cmd_rdata(link.cmd_rdata),
    .main_request(link.main_request), .aux_request(link.aux_request),
    .override_in_n(link.override_in_n), .fault_out_n_oe(link.fault_out_n_oe),
    .int_n_oe(link.int_n_oe), .fault_out_n(link.fault_out_n), .int_n(link.int_n));

  // ==========================================
  // Clock and watchdog
  initial begin
    forever #2.5 mclk_i = ~mclk_i;
  end

  // Whole run needs under a thousand cycles; a hang ends here
  initial begin
    repeat (20000) @(posedge mclk_i);
    fail_count++;
    tally_and_finish();
  end

  // ==========================================
  // Tasks
  task automatic compare(input string what, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic tally_and_finish();
    $display("Checked %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Extra edge after release keeps a strobe from being set twice in one step
  task automatic av_write(input logic [4:0] a, input logic [31:0] d);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= 1'b1;
    do @(posedge mclk_i); while (avs_waitrequest_o !== 1'b0);
    avs_write_i <= 1'b0;
    @(posedge mclk_i);
  endtask

  // A zero mask marks a poll whose value is not judged
  task automatic av_read(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
    notes.push_back('{e, m});
    avs_address_i <= a;
    avs_read_i <= 1'b1;
    do @(posedge mclk_i); while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o;
    avs_read_i <= 1'b0;
    @(posedge mclk_i);
  endtask

  task automatic dev_cmd(input logic wr, input logic [7:0] c, input logic [7:0] d);
    av_write(slot_status_pkg::AV_CMD, {15'h0, wr, c, d});
    do av_read(slot_status_pkg::AV_STATUS, 32'h0, 32'h0); while (rd[8] !== 1'b0);
  endtask

  task automatic dev_read(input logic [7:0] c, input logic [31:0] e);
    dev_cmd(1'b0, c, 8'h00);
    av_read(slot_status_pkg::AV_STATUS, e, 32'hfff);
  endtask

  // Pin register write, then time for the device's input synchronisers
  task automatic pins(input logic [1:0] m, input logic [1:0] a, input logic [1:0] o);
    av_write(slot_status_pkg::AV_PINS, {26'h0, o, a, m});
    repeat (8) @(posedge mclk_i);
  endtask

  task automatic trip(input int k, input int sl);
    case (k)
      0: aux_oc_i[sl] <= 1'b1;
      1: rail12_oc_i[sl] <= 1'b1;
      default: rail3_oc_i[sl] <= 1'b1;
    endcase
    @(posedge mclk_i);
    aux_oc_i <= 2'h0;
    rail12_oc_i <= 2'h0;
    rail3_oc_i <= 2'h0;
    repeat (8) @(posedge mclk_i);
  endtask

  task automatic check_irq(input logic e);
    repeat (2) @(posedge mclk_i);
    compare("irq", {31'h0, e}, {31'h0, irq_o});
  endtask

  // Host status word: fault pins, device interrupt, idle, last byte
  function automatic logic [31:0] st(input logic [7:0] b, input logic [1:0] p, input logic i);
    return {20'h0, p, i, 1'b0, b};
  endfunction

  // ==========================================
  // Read checker
  always @(posedge mclk_i) begin
    if (avs_read_i === 1'b1 && avs_waitrequest_o === 1'b0) begin
      cur = notes.pop_front();
      if (cur.mask !== 32'h0) begin
        compare("readdata", cur.exp & cur.mask, avs_readdata_o & cur.mask);
      end
    end
  end

  // ==========================================
  // Main sequence
  initial begin
    void'($urandom(32'hd34f));
    repeat (6) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    for (int c = 2; c < 8; c++) dev_read(8'(c), st(8'h00, 2'h3, 1'b0));
    compare("power", 32'h0, {28'h0, main_power_o, aux_power_o});
    av_read(slot_status_pkg::AV_PINS, 32'h30, 32'hffffffff);
    av_read(5'h14, 32'h0, 32'hffffffff);
    av_write(slot_status_pkg::AV_IRQ_MASK, 32'h2);
    av_read(slot_status_pkg::AV_IRQ_MASK, 32'h2, 32'hffffffff);
    // Each overcurrent kind on a random slot
    for (int k = 0; k < 3; k++) begin
      s = 8'($urandom_range(1, 0));
      sb = 2'(1 << s);
      flag = (k == 0) ? 8'h10 : (k == 1) ? 8'h04 : 8'h01;
      main_request_b = (k == 0) ? 8'h40 : 8'h20;
      pins(sb, sb, 2'h3);
      dev_read(8'h04 + s, st(8'h60, 2'h3, 1'b0));
      compare("power", {28'h0, sb, sb}, {28'h0, main_power_o, aux_power_o});
      trip(k, int'(s));
      dev_read(8'h04 + s, st(8'h80 | main_request_b | flag, ~sb, 1'b1));
      // Done bit is set too: the status reads above ran commands
      av_read(slot_status_pkg::AV_IRQ_STATUS, 32'h3, 32'h3);
      check_irq(1'b1);
      av_write(slot_status_pkg::AV_IRQ_STATUS, 32'h3);
      check_irq(1'b0);
      dev_read(8'h04 + s, st(8'h80 | main_request_b | flag, ~sb, 1'b1));
      dev_cmd(1'b1, 8'h04 + s, flag);
      dev_read(8'h04 + s, st(8'h80 | main_request_b, ~sb, 1'b0));
      if (k == 0) pins(sb, 2'h0, 2'h3);
      else pins(2'h0, sb, 2'h3);
      dev_read(8'h04 + s, st(main_request_b, 2'h3, 1'b0));
      pins(2'h0, 2'h0, 2'h3);
    end
    // Main and aux faults together on slot A
    pins(2'h1, 2'h1, 2'h3);
    trip(0, 0);
    trip(1, 0);
    pins(2'h0, 2'h1, 2'h3);
    dev_read(8'h04, st(8'h94, 2'h2, 1'b1));
    pins(2'h0, 2'h0, 2'h3);
    dev_read(8'h04, st(8'h14, 2'h3, 1'b1));
    dev_cmd(1'b1, 8'h04, 8'h04);
    dev_read(8'h04, st(8'h10, 2'h3, 1'b1));
    dev_cmd(1'b1, 8'h04, 8'h10);
    dev_read(8'h04, st(8'h00, 2'h3, 1'b0));
    // Override on slot B, then gated off
    pins(2'h2, 2'h0, 2'h3);
    trip(2, 1);
    pins(2'h2, 2'h0, 2'h1);
    dev_read(8'h05, st(8'h81, 2'h3, 1'b1));
    dev_cmd(1'b1, 8'h03, 8'h04);
    dev_read(8'h05, st(8'h81, 2'h1, 1'b1));
    dev_cmd(1'b1, 8'h03, 8'h00);
    pins(2'h0, 2'h0, 2'h3);
    dev_cmd(1'b1, 8'h05, 8'h01);
    dev_read(8'h05, st(8'h00, 2'h3, 1'b0));
    // Interrupt mask
    dev_cmd(1'b1, 8'h06, 8'h08);
    dev_read(8'h06, st(8'h08, 2'h3, 1'b0));
    pins(2'h1, 2'h0, 2'h3);
    trip(1, 0);
    dev_read(8'h04, st(8'h84, 2'h2, 1'b0));
    dev_cmd(1'b1, 8'h06, 8'h00);
    dev_read(8'h04, st(8'h84, 2'h2, 1'b1));
    pins(2'h0, 2'h0, 2'h3);
    dev_cmd(1'b1, 8'h04, 8'h04);
    // Register power control keeps the fault inactive
    dev_cmd(1'b1, 8'h02, 8'h03);
    dev_read(8'h04, st(8'h60, 2'h3, 1'b0));
    trip(1, 0);
    dev_read(8'h04, st(8'h24, 2'h3, 1'b1));
    dev_cmd(1'b1, 8'h02, 8'h00);
    dev_cmd(1'b1, 8'h04, 8'h04);
    dev_read(8'h04, st(8'h00, 2'h3, 1'b0));
    tally_and_finish();
  end
endmodule
